// ==== hdl/sdsr_drive_regs.sv ====
// sdram pad drive strength register bank with per-row code selection
`timescale 1ns/1ns
`default_nettype none
module sdsr_drive_regs (
  input  wire logic                                    i_clk_sys,
  input  wire logic                                    i_rst_n,
  // memory-mapped register port, byte address, dword data
  input  wire logic                                    i_mm_wr,
  input  wire logic                                    i_mm_rd,
  input  wire logic [sdsr_pkg::ADDR_W-1:0]             i_mm_addr,
  input  wire logic [sdsr_pkg::LANES-1:0]              i_mm_be,
  input  wire logic [sdsr_pkg::DATA_W-1:0]             i_mm_wdata,
  output logic      [sdsr_pkg::DATA_W-1:0]             o_mm_rdata,
  output logic                                         o_mm_rvalid,
  // row width bits from the row device width register
  input  wire logic [sdsr_pkg::ROWS-1:0]               i_row_device_width,
  // per-pad drive settings
  output sdsr_pkg::sdsr_drive_t [sdsr_pkg::ROWS-1:0]   o_cke_drive,
  output sdsr_pkg::sdsr_drive_t [sdsr_pkg::ROWS-1:0]   o_cs_drive,
  output sdsr_pkg::sdsr_drive_t [sdsr_pkg::CLKS-1:0]   o_clk_drive,
  output sdsr_pkg::sdsr_drive_t                        o_rcven_drive
);

  sdsr_pkg::sdsr_mm_req_t req;
  logic [sdsr_pkg::BYTE_W-1:0] reg_val [sdsr_pkg::NUM_REGS];
  logic [sdsr_pkg::DATA_W-1:0] reg_rword [sdsr_pkg::NUM_REGS];
  logic [sdsr_pkg::NUM_REGS-1:0] reg_hit;
  logic [sdsr_pkg::DATA_W-1:0] rdata_d;
  logic [sdsr_pkg::DATA_W-1:0] rdata_q;
  logic                        rvalid_q;
  sdsr_pkg::sdsr_drive_t       rcven_q;

  // bundle the request so decode sees one carrier
  assign req = '{wr: i_mm_wr, rd: i_mm_rd, addr: i_mm_addr, be: i_mm_be, wdata: i_mm_wdata};

  // per register: dword match plus the byte lane that holds it
  // only aligned dword-or-less accesses are expected, so lane alone picks the byte
  for (genvar r = 0; r < sdsr_pkg::NUM_REGS; r++) begin : g_reg
    localparam logic [sdsr_pkg::ADDR_W-1:0] OFS  = sdsr_pkg::REG_OFS[r];
    localparam logic [sdsr_pkg::LANE_W-1:0] LANE = OFS[sdsr_pkg::LANE_W-1:0];
    logic       wr_en;
    logic [7:0] wbyte;

    assign reg_hit[r] = (req.addr[sdsr_pkg::ADDR_W-1:sdsr_pkg::LANE_W] ==
                         OFS[sdsr_pkg::ADDR_W-1:sdsr_pkg::LANE_W]) && req.be[LANE];
    assign wr_en      = req.wr && reg_hit[r];
    assign wbyte      = req.wdata[LANE*sdsr_pkg::BYTE_W +: sdsr_pkg::BYTE_W];

    // offsets 31h..34h, reset 00h, masked writes
    sdsr_strength_reg #(
      .MASK (sdsr_pkg::REG_MASK[r])
    ) u_reg (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_wr      (wr_en),
      .i_wdata   (wbyte),
      .o_q       (reg_val[r])
    );

    // place the byte in its lane for the read mux
    assign reg_rword[r] = reg_hit[r] ?
      (sdsr_pkg::DATA_W'(reg_val[r]) << (LANE*sdsr_pkg::BYTE_W)) : '0;
  end

  // unmapped bytes read zero; lanes of different registers never overlap
  always_comb begin
    rdata_d = '0;
    for (int r = 0; r < sdsr_pkg::NUM_REGS; r++) begin
      rdata_d = rdata_d | reg_rword[r];
    end
  end

  // read answer one cycle after the strobe, held until the next read
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= '0;
    end else if (req.rd) begin
      rdata_q <= rdata_d;
    end
  end

  // valid pulse for exactly one cycle per read strobe
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
    end
  end

  assign o_mm_rdata  = rdata_q;
  assign o_mm_rvalid = rvalid_q;

  // clock-enable and chip-select: one output per row, own row width
  for (genvar n = 0; n < sdsr_pkg::ROWS; n++) begin : g_row
    sdsr_row_drive u_cke (
      .i_clk_sys  (i_clk_sys),
      .i_rst_n    (i_rst_n),
      .i_row_x8   (i_row_device_width[n]),
      .i_code_x16 (reg_val[sdsr_pkg::REG_CKE][sdsr_pkg::X16_LSB +: sdsr_pkg::CODE_W]),
      .i_code_x8  (reg_val[sdsr_pkg::REG_CKE][sdsr_pkg::X8_LSB +: sdsr_pkg::CODE_W]),
      .o_drive    (o_cke_drive[n])
    );
    sdsr_row_drive u_cs (
      .i_clk_sys  (i_clk_sys),
      .i_rst_n    (i_rst_n),
      .i_row_x8   (i_row_device_width[n]),
      .i_code_x16 (reg_val[sdsr_pkg::REG_CS][sdsr_pkg::X16_LSB +: sdsr_pkg::CODE_W]),
      .i_code_x8  (reg_val[sdsr_pkg::REG_CS][sdsr_pkg::X8_LSB +: sdsr_pkg::CODE_W]),
      .o_drive    (o_cs_drive[n])
    );
  end

  // clock pairs: true and complement share one setting, row fixed per pair
  for (genvar k = 0; k < sdsr_pkg::CLKS; k++) begin : g_clk
    sdsr_row_drive u_ck (
      .i_clk_sys  (i_clk_sys),
      .i_rst_n    (i_rst_n),
      .i_row_x8   (i_row_device_width[sdsr_pkg::CLK_ROW[k]]),
      .i_code_x16 (reg_val[sdsr_pkg::REG_CK][sdsr_pkg::X16_LSB +: sdsr_pkg::CODE_W]),
      .i_code_x8  (reg_val[sdsr_pkg::REG_CK][sdsr_pkg::X8_LSB +: sdsr_pkg::CODE_W]),
      .o_drive    (o_clk_drive[k])
    );
  end

  // read-clock-out has one code, no width dependence
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rcven_q <= sdsr_pkg::DRIVE_RST;
    end else begin
      rcven_q.code     <= reg_val[sdsr_pkg::REG_RCV][sdsr_pkg::X8_LSB +: sdsr_pkg::CODE_W];
      rcven_q.quarters <= sdsr_pkg::sdsr_quarters(
                            reg_val[sdsr_pkg::REG_RCV][sdsr_pkg::X8_LSB +: sdsr_pkg::CODE_W]);
    end
  end

  assign o_rcven_drive = rcven_q;

  // checks on the register port and the drive outputs

  chk_cke_write_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_mm_wr && i_mm_addr[8:2] == 7'h0C && i_mm_be[1]) ##1 (i_mm_rd && !i_mm_wr && i_mm_addr[8:2] == 7'h0C
      && i_mm_be[1])
    |=> o_mm_rvalid && o_mm_rdata[15:8] == ($past(i_mm_wdata[15:8], 2) & 8'h77))
    else $error("clock enable strength readback wrong");

  chk_cs_write_lands: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_mm_wr && i_mm_addr[8:2] == 7'h0C && i_mm_be[2] && i_row_device_width[0]) ##1
      i_row_device_width[0]
    |=> o_cs_drive[0].code == $past(i_mm_wdata[18:16], 2))
    else $error("chip select x8 code not applied");

  chk_ck_x16_lands: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_mm_wr && i_mm_addr[8:2] == 7'h0C && i_mm_be[3] && !i_row_device_width[1]) ##1
      !i_row_device_width[1]
    |=> o_clk_drive[3].code == $past(i_mm_wdata[30:28], 2))
    else $error("clock x16 code not applied");

  chk_rcv_write_lands: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_mm_wr && i_mm_addr[8:2] == 7'h0D && i_mm_be[0])
    |=> ##1 o_rcven_drive.code == $past(i_mm_wdata[2:0], 2))
    else $error("read clock out code not applied");

  chk_rcv_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_mm_rd && i_mm_addr[8:2] == 7'h0D) |=> o_mm_rdata[31:3] == 29'h0)
    else $error("reserved bits of 34h dword not zero");

  chk_clock_pair_rows: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_clk_drive[0] == o_clk_drive[2] && o_clk_drive[1] == o_clk_drive[3] &&
    o_clk_drive[4] == o_clk_drive[6] && o_clk_drive[9] == o_clk_drive[11])
    else $error("clocks of one row disagree");

  chk_clock_follows_row: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    ##1 o_clk_drive[8] == o_cke_drive[4] ||
        $past(reg_val[sdsr_pkg::REG_CK]) != $past(reg_val[sdsr_pkg::REG_CKE]))
    else $error("clock 8 not tied to row 4");

  // valid follows the strobe by exactly one edge, and never shows up unasked
  chk_read_one_cycle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_mm_rd |=> o_mm_rvalid) and (!i_mm_rd |=> !o_mm_rvalid))
    else $error("read valid timing wrong");

  chk_unmapped_reads_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_mm_rd && i_mm_addr[8:2] != 7'h0C && i_mm_addr[8:2] != 7'h0D) |=> o_mm_rdata == 32'h0)
    else $error("unmapped read not zero");

  // x8 rows of the clock-enable group take the low field
  chk_cke_x8_lands: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_mm_wr && i_mm_addr[8:2] == 7'h0C && i_mm_be[1] && i_row_device_width[3]) ##1
      i_row_device_width[3]
    |=> o_cke_drive[3].code == $past(i_mm_wdata[10:8], 2))
    else $error("clock enable x8 code not applied");

  // x16 or empty rows of the chip-select group take the high field
  chk_cs_x16_lands: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_mm_wr && i_mm_addr[8:2] == 7'h0C && i_mm_be[2] && !i_row_device_width[5]) ##1
      !i_row_device_width[5]
    |=> o_cs_drive[5].code == $past(i_mm_wdata[22:20], 2))
    else $error("chip select x16 code not applied");

  // clock 11 belongs to row 5, so an x8 row 5 gives it the low field
  chk_ck_x8_lands: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_mm_wr && i_mm_addr[8:2] == 7'h0C && i_mm_be[3] && i_row_device_width[5]) ##1
      i_row_device_width[5]
    |=> o_clk_drive[11].code == $past(i_mm_wdata[26:24], 2))
    else $error("clock x8 code not applied");

  chk_clock_pair_more: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_clk_drive[5] == o_clk_drive[7] && o_clk_drive[8] == o_clk_drive[10])
    else $error("clocks of rows 3 or 4 disagree");

endmodule // sdsr_drive_regs
`default_nettype wire

// ==== hdl/sdsr_pkg.sv ====
// constants, types and helpers shared by the sdram drive strength register bank
package sdsr_pkg;

  // memory-mapped port geometry
  localparam int unsigned ADDR_W   = 9;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned LANES    = 4;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned LANE_W   = 2;

  // strength register bank
  localparam int unsigned NUM_REGS = 4;
  localparam int unsigned REG_CKE  = 0;
  localparam int unsigned REG_CS   = 1;
  localparam int unsigned REG_CK   = 2;
  localparam int unsigned REG_RCV  = 3;

  localparam logic [ADDR_W-1:0] OFS_CKE = 9'h031;
  localparam logic [ADDR_W-1:0] OFS_CS  = 9'h032;
  localparam logic [ADDR_W-1:0] OFS_CK  = 9'h033;
  localparam logic [ADDR_W-1:0] OFS_RCV = 9'h034;
  localparam logic [ADDR_W-1:0] REG_OFS [NUM_REGS] = '{OFS_CKE, OFS_CS, OFS_CK, OFS_RCV};

  // writable bits; reserved bits 7 and 3 (or 7:3) are held at zero
  localparam logic [BYTE_W-1:0] MASK_PAIR = 8'h77;
  localparam logic [BYTE_W-1:0] MASK_ONE  = 8'h07;
  localparam logic [BYTE_W-1:0] REG_MASK [NUM_REGS] = '{MASK_PAIR, MASK_PAIR, MASK_PAIR, MASK_ONE};
  localparam logic [BYTE_W-1:0] REG_RST   = 8'h00;

  // code fields
  localparam int unsigned CODE_W  = 3;
  localparam int unsigned X16_LSB = 4;
  localparam int unsigned X8_LSB  = 0;

  // memory rows and clock pairs
  localparam int unsigned ROWS    = 6;
  localparam int unsigned CLKS    = 12;
  localparam int unsigned ROW_IDX_W = 3;
  // fixed row served by each clock pair: 0,1,0,1,2,3,2,3,4,5,4,5
  localparam logic [ROW_IDX_W-1:0] CLK_ROW [CLKS] = '{
    3'h0, 3'h1, 3'h0, 3'h1, 3'h2, 3'h3, 3'h2, 3'h3, 3'h4, 3'h5, 3'h4, 3'h5};

  // strength expressed in quarters of the nominal drive
  localparam int unsigned QTR_W = 5;

  typedef struct packed {
    logic [CODE_W-1:0] code;      // raw code handed to the pad
    logic [QTR_W-1:0]  quarters;  // decoded strength, 4 = 1.00x
  } sdsr_drive_t;

  localparam sdsr_drive_t DRIVE_RST = '{code: 3'h0, quarters: 5'h03};

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0]  be;
    logic [DATA_W-1:0] wdata;
  } sdsr_mm_req_t;

  // code to strength: 0.75x up to 4.00x
  function automatic logic [QTR_W-1:0] sdsr_quarters(input logic [CODE_W-1:0] code);
    logic [QTR_W-1:0] q;
    q = 5'h03;
    unique case (code)
      3'h0: q = 5'h03;
      3'h1: q = 5'h04;
      3'h2: q = 5'h05;
      3'h3: q = 5'h06;
      3'h4: q = 5'h08;
      3'h5: q = 5'h0A;
      3'h6: q = 5'h0C;
      3'h7: q = 5'h10;
    endcase
    return q;
  endfunction

endpackage

// ==== hdl/sdsr_row_drive.sv ====
// picks the x8 or x16 code for one output from its row width bit and decodes it
`timescale 1ns/1ns
`default_nettype none
module sdsr_row_drive (
  input  wire logic                                 i_clk_sys,
  input  wire logic                                 i_rst_n,
  input  wire logic                                 i_row_x8,
  input  wire logic [sdsr_pkg::CODE_W-1:0]          i_code_x16,
  input  wire logic [sdsr_pkg::CODE_W-1:0]          i_code_x8,
  output sdsr_pkg::sdsr_drive_t                     o_drive
);

  sdsr_pkg::sdsr_drive_t drive_q;
  logic [sdsr_pkg::CODE_W-1:0] code_d;

  // width bit 0 means x16 or empty row, 1 means x8 row
  assign code_d = i_row_x8 ? i_code_x8 : i_code_x16;

  // registered so the pad sees a glitch-free code when width or strength changes
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drive_q <= sdsr_pkg::DRIVE_RST;
    end else begin
      drive_q.code     <= code_d;
      drive_q.quarters <= sdsr_pkg::sdsr_quarters(code_d);
    end
  end

  assign o_drive = drive_q;

  chk_width_selects_code: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    ##1 o_drive.code == ($past(i_row_x8) ? $past(i_code_x8) : $past(i_code_x16)))
    else $error("wrong width code selected");

  chk_code_to_strength: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (o_drive.code == 3'h0 |-> o_drive.quarters == 5'h03) and
    (o_drive.code == 3'h4 |-> o_drive.quarters == 5'h08) and
    (o_drive.code == 3'h7 |-> o_drive.quarters == 5'h10))
    else $error("strength decode mismatch");

endmodule // sdsr_row_drive
`default_nettype wire

// ==== hdl/sdsr_strength_reg.sv ====
// one 8-bit strength register with reserved bits forced to zero
`timescale 1ns/1ns
`default_nettype none
module sdsr_strength_reg #(
  parameter logic [7:0] MASK = 8'h77
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_q
);

  logic [7:0] val_q;

  // reserved bits never store, so they always read back as zero
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      val_q <= sdsr_pkg::REG_RST;
    end else if (i_wr) begin
      val_q <= i_wdata & MASK;
    end
  end

  assign o_q = val_q;

  chk_reserved_stay_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (val_q & ~MASK) == 8'h00)
    else $error("reserved strength bit set");

  chk_write_takes_value: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_wr |=> val_q == ($past(i_wdata) & MASK))
    else $error("strength write not stored");

endmodule // sdsr_strength_reg
`default_nettype wire

// ==== tb/sdsr_drive_regs_tb.sv ====
// self-checking bench for the drive strength register bank
`timescale 1ns/1ns
`default_nettype none
module sdsr_drive_regs_tb;
  logic                            clk_sys, rst_n, mm_wr, mm_rd, mm_rvalid, pad_bad;
  logic [8:0]                      mm_addr;
  logic [3:0]                      mm_be;
  logic [31:0]                     mm_wdata, mm_rdata, rdw;
  logic [5:0]                      row_w;
  sdsr_pkg::sdsr_drive_t [5:0]     cke_d, cs_d;
  sdsr_pkg::sdsr_drive_t [11:0]    clk_d;
  sdsr_pkg::sdsr_drive_t           rcv_d;
  int                              miscompares, n_checks, cycles;
  int                              reg_m [4];
  int                              mask [4] = '{'h77, 'h77, 'h77, 'h07};
  int                              qtab [8] = '{3, 4, 5, 6, 8, 10, 12, 16};
  int                              rowmap [12] = '{0, 1, 0, 1, 2, 3, 2, 3, 4, 5, 4, 5};
  logic [8:0]                      dws [4] = '{9'h030, 9'h034, 9'h02C, 9'h038};

  sdsr_drive_regs i_sdsr_drive_regs (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_mm_wr(mm_wr), .i_mm_rd(mm_rd),
    .i_mm_addr(mm_addr), .i_mm_be(mm_be), .i_mm_wdata(mm_wdata), .o_mm_rdata(mm_rdata),
    .o_mm_rvalid(mm_rvalid), .i_row_device_width(row_w), .o_cke_drive(cke_d),
    .o_cs_drive(cs_d), .o_clk_drive(clk_d), .o_rcven_drive(rcv_d));

  sdsr_pad_model i_sdsr_pad_model (.i_drive({rcv_d, clk_d, cs_d, cke_d}), .o_bad(pad_bad));

  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // hang guard: the full run needs only about seven hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // the model keeps only writable bits of mapped bytes
  function automatic void model_wr(input logic [8:0] a, input logic [3:0] be, input logic [31:0] d);
    int b;
    for (int l = 0; l < 4; l++) begin
      b = int'(a[8:2]) * 4 + l;
      if (be[l] && b >= 'h31 && b <= 'h34) reg_m[b - 'h31] = int'(d[8*l +: 8]) & mask[b - 'h31];
    end
  endfunction

  // single-cycle write pulse
  task automatic wr(input logic [8:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_sys);
    mm_wr <= 1'b1;
    mm_addr <= a;
    mm_be <= be;
    mm_wdata <= d;
    @(posedge clk_sys);
    mm_wr <= 1'b0;
    model_wr(a, be, d);
  endtask

  // write, then a read of the same dword on the very next edge: it must see the new bytes
  task automatic wr_rd(input logic [8:0] a, input logic [3:0] be, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys);
    mm_wr <= 1'b1;
    mm_addr <= a;
    mm_be <= be;
    mm_wdata <= d;
    @(posedge clk_sys);
    mm_wr <= 1'b0;
    mm_rd <= 1'b1;
    mm_be <= 4'hF;
    model_wr(a, be, d);
    @(posedge clk_sys);
    mm_rd <= 1'b0;
    #1;
    chk("rvalid", 32'h1, {31'h0, mm_rvalid});
    q = mm_rdata;
  endtask

  // answer is registered, so it is looked at just after the edge that took the read
  task automatic rd(input logic [8:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    mm_rd <= 1'b1;
    mm_addr <= a;
    mm_be <= 4'hF;
    @(posedge clk_sys);
    mm_rd <= 1'b0;
    #1;
    chk("rvalid", 32'h1, {31'h0, mm_rvalid});
    d = mm_rdata;
  endtask

  function automatic logic [31:0] exp_drv(input int i, input logic x8);
    int c;
    c = x8 ? (reg_m[i] & 7) : ((reg_m[i] >> 4) & 7);
    return {24'h0, 3'(c), 5'(qtab[c])};
  endfunction

  task automatic check_all();
    logic [31:0] d;
    #1;
    for (int r = 0; r < 6; r++) begin
      chk("cke drive", exp_drv(0, row_w[r]), {24'h0, cke_d[r]});
      chk("cs drive", exp_drv(1, row_w[r]), {24'h0, cs_d[r]});
    end
    for (int k = 0; k < 12; k++) begin
      chk("clk drive", exp_drv(2, row_w[rowmap[k]]), {24'h0, clk_d[k]});
    end
    chk("rcv drive", exp_drv(3, 1'b1), {24'h0, rcv_d});
    chk("pad decode", 32'h0, {31'h0, pad_bad});
    rd(9'h030, d);
    chk("dword 30", {8'(reg_m[2]), 8'(reg_m[1]), 8'(reg_m[0]), 8'h00}, d);
    rd(9'h034, d);
    chk("dword 34", {24'h0, 8'(reg_m[3])}, d);
    rd(9'h02C, d);
    chk("unmapped", 32'h0, d);
  endtask

  // reset clears every register back to the weakest code
  task automatic do_reset(input int n);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    rst_n <= 1'b1;
    reg_m = '{0, 0, 0, 0};
    check_all();
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence: random widths and partial-lane writes, including unmapped dwords
  initial begin
    rst_n = 1'b0;
    mm_wr = 1'b0;
    mm_rd = 1'b0;
    mm_addr = 9'h000;
    mm_be = 4'h0;
    mm_wdata = 32'h0;
    row_w = 6'h00;
    void'($urandom(32'hD015));
    do_reset(10);
    for (int it = 0; it < 40; it++) begin
      row_w <= 6'($urandom);
      wr(dws[$urandom % 4], 4'($urandom), $urandom);
      wr(9'h034, 4'($urandom), $urandom);
      wr_rd(9'h030, 4'($urandom), $urandom, rdw);
      chk("dword 30 b2b", {8'(reg_m[2]), 8'(reg_m[1]), 8'(reg_m[0]), 8'h00}, rdw);
      repeat (3) @(posedge clk_sys);
      check_all();
      if (it == 20) do_reset(2);
    end
    test_done();
  end
endmodule // sdsr_drive_regs_tb
`default_nettype wire

// ==== tb/sdsr_pad_model.sv ====
// pad buffer model: turns each received code into a strength and flags a decode slip
`timescale 1ns/1ns
`default_nettype none
module sdsr_pad_model (
  input  wire sdsr_pkg::sdsr_drive_t [24:0] i_drive,
  output logic                              o_bad
);
  // strength in quarters of nominal, code 0 is the weakest default
  localparam int QTR [8] = '{3, 4, 5, 6, 8, 10, 12, 16};

  // each pad (true and complement clock share one entry) checks its own setting
  always_comb begin
    o_bad = 1'b0;
    for (int p = 0; p < 25; p++) begin
      if (i_drive[p].quarters !== 5'(QTR[i_drive[p].code])) begin
        o_bad = 1'b1;
      end
    end
  end
endmodule // sdsr_pad_model
`default_nettype wire
